/* File: fpo_flash_protection_host.sv */
// host controller for the flash protection and secure overlays
// Operation
// - lock word read and programmed only at address 0; raw cycles keep the written address
// - guard change lock accessed at address 0
// - ecc overlay entered from read mode; program and raw cycles refused inside it
// - sector guard accessed at sector offset 0
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fpo_flash_protection_host #(
    parameter int ADDR_W = 25
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic [ADDR_W-1:0] FLASH_A,
    input wire logic [15:0] FLASH_DQ_I,
    output logic [15:0] FLASH_DQ_O,
    output logic FLASH_DQ_OE,
    output logic FLASH_CE_N,
    output logic FLASH_OE_N,
    output logic FLASH_WE_N,
    output logic BUSY
);
    if (ADDR_W < 17 || ADDR_W > 32)
    begin : g_bad_width
        $error("ADDR_W must lie between 17 and 32");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } fpo_state_type;
    localparam int SEC_W = ADDR_W - fpo_pkg::SECTOR_LSB;

    fpo_state_type state_ff;
    fpo_pkg::fpo_mode_type mode_ff;
    logic [SEC_W-1:0] ovl_sector_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [15:0] wdata_ff, rdata_ff;
    logic [3:0] gate_ff;
    logic refused_ff, pend_read_ff, undef_ff, guard_ff, busy_ff;
    logic [1:0] region_ff;
    logic [2:0] ecc_ff;
    logic [31:0] reg_rdata_ff;
    wire logic [2:0] op, kind;
    wire logic go, ctrl_busy, sector_match, sec_undef, pw_undef, is_prog, bad_op;
    wire logic refuse_ecc_enter, refuse_ecc_prog, refuse_secure_prog, refuse_secure_read;
    wire logic refuse, accept, cyc_done;
    wire logic [1:0] region;
    wire logic [ADDR_W-1:0] eff_addr;
    wire fpo_pkg::fpo_cyc_req_type cyc_req;
    wire logic [15:0] cyc_rdata;
    wire logic [31:0] status_word, rd_mux;

    assign op = REG_WDATA[fpo_pkg::CTRL_OP_LSB +: 3];
    assign kind = REG_WDATA[fpo_pkg::CTRL_KIND_LSB +: 3];
    assign go = REG_WR && REG_ADDR == fpo_pkg::REG_CTRL && state_ff == ST_IDLE;
    assign ctrl_busy = REG_WR && REG_ADDR == fpo_pkg::REG_CTRL && state_ff != ST_IDLE;

    // secure overlay decode from the sector number and the word offset; password overlay word range
    assign sector_match = addr_ff[ADDR_W-1:fpo_pkg::SECTOR_LSB] == ovl_sector_ff;
    assign region = addr_ff[fpo_pkg::REGION_LSB +: 2];
    assign sec_undef = addr_ff[fpo_pkg::SECTOR_LSB-1:fpo_pkg::SECURE_HIGH_LSB] != '0;
    assign pw_undef = 32'(addr_ff) >= fpo_pkg::PASSWORD_WORDS;

    assign is_prog = op == fpo_pkg::OP_PROGRAM || op == fpo_pkg::OP_RAW;
    assign bad_op = op == fpo_pkg::OP_NONE || op > fpo_pkg::OP_EXIT;
    assign refuse_ecc_enter = op == fpo_pkg::OP_ENTER && kind == fpo_pkg::MODE_ECC
        && mode_ff != fpo_pkg::MODE_NORMAL;
    assign refuse_ecc_prog = mode_ff == fpo_pkg::MODE_ECC && is_prog;
    // raw cycles are unguarded so software can still send unlock prefixes
    assign refuse_secure_prog = mode_ff == fpo_pkg::MODE_SECURE && op == fpo_pkg::OP_PROGRAM
        && (!sector_match
        || sec_undef
        || region == fpo_pkg::REGION_FACTORY
        || (region == fpo_pkg::REGION_A && gate_ff[fpo_pkg::GATE_A_LOCKED])
        || (region == fpo_pkg::REGION_B && gate_ff[fpo_pkg::GATE_B_LOCKED])
        || (region == fpo_pkg::REGION_PW && (!gate_ff[fpo_pkg::GATE_PW_GIVEN]
        || gate_ff[fpo_pkg::GATE_PW_LOCKED])));
    assign refuse_secure_read = mode_ff == fpo_pkg::MODE_SECURE && op == fpo_pkg::OP_READ
        && sector_match && !sec_undef && region == fpo_pkg::REGION_PW
        && !gate_ff[fpo_pkg::GATE_PW_GIVEN];
    assign refuse = bad_op || refuse_ecc_enter || refuse_ecc_prog || refuse_secure_prog
        || refuse_secure_read;
    assign accept = go && !refuse;

    // read and program cycles of single-word overlays and sector guards are touched at offset 0
    assign eff_addr = (op == fpo_pkg::OP_READ || op == fpo_pkg::OP_PROGRAM)
        ? ((mode_ff == fpo_pkg::MODE_LOCKWORD) ? '0
        : (mode_ff == fpo_pkg::MODE_LOCKBIT) ? '0
        : (mode_ff == fpo_pkg::MODE_NVGUARD || mode_ff == fpo_pkg::MODE_VGUARD)
        ? {addr_ff[ADDR_W-1:fpo_pkg::SECTOR_LSB], 16'h0000}
        : addr_ff)
        : addr_ff;
    assign cyc_req = '{write: op != fpo_pkg::OP_READ, addr: 32'(eff_addr), data: wdata_ff};

    assign status_word = {20'h00000, undef_ff, 1'b0, region_ff, 1'b0, mode_ff, 2'b00,
        refused_ff, busy_ff};
    assign rd_mux = (REG_ADDR == fpo_pkg::REG_ADDR) ? 32'(addr_ff)
        : (REG_ADDR == fpo_pkg::REG_WDATA) ? {16'h0000, wdata_ff}
        : (REG_ADDR == fpo_pkg::REG_STATUS) ? status_word
        : (REG_ADDR == fpo_pkg::REG_RDATA) ? {16'h0000, rdata_ff}
        : (REG_ADDR == fpo_pkg::REG_DECODE) ? {28'h0000000, ecc_ff, guard_ff}
        : (REG_ADDR == fpo_pkg::REG_GATE) ? {28'h0000000, gate_ff}
        : 32'h0000_0000;

    fpo_flash_cycle #(
        .ADDR_W(ADDR_W)
    ) u_cycle (
        .clk(CLK),
        .rst_n(RST_N),
        .start(accept),
        .req(cyc_req),
        .dq_i(FLASH_DQ_I),
        .a_ff(FLASH_A),
        .dq_o_ff(FLASH_DQ_O),
        .dq_oe_ff(FLASH_DQ_OE),
        .ce_n_ff(FLASH_CE_N),
        .oe_n_ff(FLASH_OE_N),
        .we_n_ff(FLASH_WE_N),
        .rdata_ff(cyc_rdata),
        .done_ff(cyc_done)
    );

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
            refused_ff <= 1'b0;
            pend_read_ff <= 1'b0;
        end
        else
        begin
            if (accept)
            begin
                state_ff <= ST_WAIT;
                busy_ff <= 1'b1;
                pend_read_ff <= op == fpo_pkg::OP_READ;
            end
            else if (cyc_done)
            begin
                state_ff <= ST_IDLE;
                busy_ff <= 1'b0;
                pend_read_ff <= 1'b0;
            end
            refused_ff <= !accept && (refused_ff || (go && refuse) || ctrl_busy);
        end
    end

    // overlay tracking; mode switches when the entry or exit cycle is taken
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mode_ff <= fpo_pkg::MODE_NORMAL;
            ovl_sector_ff <= '0;
        end
        else if (accept && op == fpo_pkg::OP_ENTER)
        begin
            mode_ff <= fpo_pkg::fpo_mode_type'(kind);
            ovl_sector_ff <= addr_ff[ADDR_W-1:fpo_pkg::SECTOR_LSB];
        end
        else if (accept && op == fpo_pkg::OP_EXIT)
            mode_ff <= fpo_pkg::MODE_NORMAL;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            addr_ff <= '0;
            wdata_ff <= 16'h0000;
            gate_ff <= fpo_pkg::GATE_RESET;
            reg_rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            if (REG_WR && REG_ADDR == fpo_pkg::REG_ADDR)
                addr_ff <= REG_WDATA[ADDR_W-1:0];
            if (REG_WR && REG_ADDR == fpo_pkg::REG_WDATA)
                wdata_ff <= REG_WDATA[15:0];
            if (REG_WR && REG_ADDR == fpo_pkg::REG_GATE)
                gate_ff <= REG_WDATA[3:0];
            reg_rdata_ff <= REG_RD ? rd_mux : 32'h0000_0000;
        end
    end

    // decode of the last accepted address and of the word that the last read returned
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            region_ff <= 2'h0;
            undef_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            ecc_ff <= 3'h0;
            guard_ff <= 1'b0;
        end
        else
        begin
            if (accept)
            begin
                region_ff <= region;
                undef_ff <= (mode_ff == fpo_pkg::MODE_SECURE && sector_match && sec_undef)
                    || (mode_ff == fpo_pkg::MODE_PASSWORD && pw_undef);
            end
            if (cyc_done && pend_read_ff)
            begin
                rdata_ff <= cyc_rdata;
                // reserved bits 15:4 and 0 are dropped
                if (mode_ff == fpo_pkg::MODE_ECC)
                    ecc_ff <= {cyc_rdata[fpo_pkg::ECC_DISABLED_BIT],
                        cyc_rdata[fpo_pkg::ECC_CHECK_FIX_BIT],
                        cyc_rdata[fpo_pkg::ECC_DATA_FIX_BIT]};
                if (mode_ff == fpo_pkg::MODE_NVGUARD || mode_ff == fpo_pkg::MODE_VGUARD
                    || mode_ff == fpo_pkg::MODE_LOCKBIT)
                    guard_ff <= cyc_rdata[fpo_pkg::GUARD_BIT];
            end
        end
    end

    assign REG_RDATA = reg_rdata_ff;
    assign BUSY = busy_ff;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_ecc_entry_gate: assert property (
        go && op == fpo_pkg::OP_ENTER && kind == fpo_pkg::MODE_ECC
        && mode_ff != fpo_pkg::MODE_NORMAL |=> refused_ff && !busy_ff && FLASH_CE_N)
        else $error("ecc entry outside read mode was issued");
    a_ecc_no_program: assert property (
        go && mode_ff == fpo_pkg::MODE_ECC && is_prog |=> refused_ff && $stable(mode_ff))
        else $error("program cycle issued inside ecc overlay");
    a_lockword_addr: assert property (
        accept && mode_ff == fpo_pkg::MODE_LOCKWORD && op == fpo_pkg::OP_READ
        |=> FLASH_A == '0 && !FLASH_CE_N)
        else $error("lock word accessed away from address 0");
    a_lockbit_addr: assert property (
        accept && mode_ff == fpo_pkg::MODE_LOCKBIT && op != fpo_pkg::OP_EXIT |=> FLASH_A == '0)
        else $error("guard change lock accessed away from address 0");
    a_guard_offset: assert property (
        accept && mode_ff == fpo_pkg::MODE_NVGUARD && op == fpo_pkg::OP_READ
        |=> FLASH_A[15:0] == 16'h0000 ##[1:20] cyc_done)
        else $error("sector guard not accessed at sector offset 0");
    a_secure_sector: assert property (
        accept && op == fpo_pkg::OP_ENTER && kind == fpo_pkg::MODE_SECURE
        |=> ovl_sector_ff == FLASH_A[ADDR_W-1:fpo_pkg::SECTOR_LSB]
        && mode_ff == fpo_pkg::MODE_SECURE)
        else $error("overlay sector not taken from entry address");
    a_outside_refuse: assert property (
        go && mode_ff == fpo_pkg::MODE_SECURE && op == fpo_pkg::OP_PROGRAM && !sector_match
        |=> refused_ff ##1 FLASH_WE_N)
        else $error("program outside overlay sector was issued");
    a_factory_refuse: assert property (
        go && mode_ff == fpo_pkg::MODE_SECURE && op == fpo_pkg::OP_PROGRAM && sector_match
        && region == fpo_pkg::REGION_FACTORY |=> refused_ff && !busy_ff)
        else $error("program of factory region was issued");
    a_pw_read_gate: assert property (
        go && refuse_secure_read |=> refused_ff && FLASH_OE_N)
        else $error("password region read without password");
    a_exit_map: assert property (
        accept && op == fpo_pkg::OP_EXIT |=> mode_ff == fpo_pkg::MODE_NORMAL)
        else $error("exit did not restore normal map");
    a_undef_flag: assert property (
        accept && mode_ff == fpo_pkg::MODE_SECURE && sector_match && sec_undef |=> undef_ff)
        else $error("undefined secure offset not flagged");

    c_enter_secure: cover property (accept && op == fpo_pkg::OP_ENTER
        && kind == fpo_pkg::MODE_SECURE);
    c_ecc_read: cover property (cyc_done && pend_read_ff && mode_ff == fpo_pkg::MODE_ECC);
    c_refused: cover property (go && refuse_secure_prog);
    c_exit: cover property (accept && op == fpo_pkg::OP_EXIT);
endmodule
`default_nettype wire

/* File: fpo_pkg.sv */
// package: constants, types and register map of the flash protection overlay host
package fpo_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int READ_STROBE_NS = 120;
    localparam int READ_STROBE_CYC = (READ_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_STROBE_NS = 60;
    localparam int WRITE_STROBE_CYC = (WRITE_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int SECTOR_LSB = 16;
    localparam int REGION_LSB = 8;
    localparam int SECURE_HIGH_LSB = 10;
    localparam logic [31:0] PASSWORD_WORDS = 32'h0000_0004;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_DECODE = 8'h14;
    localparam logic [7:0] REG_GATE = 8'h18;

    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_KIND_LSB = 4;

    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_REGION_LSB = 8;
    localparam int ST_UNDEF = 11;

    localparam int ECC_DISABLED_BIT = 3;
    localparam int ECC_CHECK_FIX_BIT = 2;
    localparam int ECC_DATA_FIX_BIT = 1;
    localparam int GUARD_BIT = 0;

    localparam int GATE_A_LOCKED = 0;
    localparam int GATE_B_LOCKED = 1;
    localparam int GATE_PW_LOCKED = 2;
    localparam int GATE_PW_GIVEN = 3;
    localparam logic [3:0] GATE_RESET = 4'h0;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_SECURE = 3'h1,
        MODE_LOCKWORD = 3'h2,
        MODE_NVGUARD = 3'h3,
        MODE_LOCKBIT = 3'h4,
        MODE_PASSWORD = 3'h5,
        MODE_VGUARD = 3'h6,
        MODE_ECC = 3'h7
    } fpo_mode_type;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_READ = 3'h1,
        OP_PROGRAM = 3'h2,
        OP_RAW = 3'h3,
        OP_ENTER = 3'h4,
        OP_EXIT = 3'h5
    } fpo_op_type;

    typedef enum logic [1:0] {
        REGION_FACTORY = 2'h0,
        REGION_A = 2'h1,
        REGION_B = 2'h2,
        REGION_PW = 2'h3
    } fpo_region_type;

    typedef struct packed {
        logic write;
        logic [31:0] addr;
        logic [15:0] data;
    } fpo_cyc_req_type;

endpackage

/* File: fpo_flash_cycle.sv */
// one asynchronous flash bus cycle, read or write, timed in clock cycles
`timescale 1ns/1ps
`default_nettype none
module fpo_flash_cycle #(
    parameter int ADDR_W = 25
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire fpo_pkg::fpo_cyc_req_type req,
    input wire logic [15:0] dq_i,
    output logic [ADDR_W-1:0] a_ff,
    output logic [15:0] dq_o_ff,
    output logic dq_oe_ff,
    output logic ce_n_ff,
    output logic oe_n_ff,
    output logic we_n_ff,
    output logic [15:0] rdata_ff,
    output logic done_ff
);
    typedef enum logic [3:0] {
        CY_IDLE = 4'b0001,
        CY_SETUP = 4'b0010,
        CY_STROBE = 4'b0100,
        CY_HOLD = 4'b1000
    } fpo_cy_state_type;

    fpo_cy_state_type state_ff;
    logic wr_ff;
    logic [7:0] cnt_ff;
    wire logic [7:0] strobe_len;

    // strobe length minus one, since the setup edge already counts
    assign strobe_len = wr_ff ? 8'(fpo_pkg::WRITE_STROBE_CYC - 1) : 8'(fpo_pkg::READ_STROBE_CYC - 1);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= CY_IDLE;
            wr_ff <= 1'b0;
            cnt_ff <= 8'h00;
            a_ff <= '0;
            dq_o_ff <= 16'h0000;
            dq_oe_ff <= 1'b0;
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            rdata_ff <= 16'h0000;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            case (state_ff)
                CY_IDLE:
                begin
                    if (start)
                    begin
                        a_ff <= req.addr[ADDR_W-1:0];
                        dq_o_ff <= req.data;
                        wr_ff <= req.write;
                        dq_oe_ff <= req.write;
                        ce_n_ff <= 1'b0;
                        state_ff <= CY_SETUP;
                    end
                end
                CY_SETUP:
                begin
                    oe_n_ff <= wr_ff;
                    we_n_ff <= !wr_ff;
                    cnt_ff <= strobe_len;
                    state_ff <= CY_STROBE;
                end
                CY_STROBE:
                begin
                    if (cnt_ff == 8'h00)
                    begin
                        if (!wr_ff)
                        begin
                            rdata_ff <= dq_i;
                        end
                        oe_n_ff <= 1'b1;
                        we_n_ff <= 1'b1;
                        state_ff <= CY_HOLD;
                    end
                    else
                    begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                CY_HOLD:
                begin
                    // data held one cycle past the write strobe edge
                    ce_n_ff <= 1'b1;
                    dq_oe_ff <= 1'b0;
                    done_ff <= 1'b1;
                    state_ff <= CY_IDLE;
                end
                default:
                begin
                    state_ff <= CY_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: fpo_flash_model.sv */
// behavioural flash device answering the protection overlays
`timescale 1ns/1ps
`default_nettype none
module fpo_flash_model #(
    parameter logic [15:0] LOCK_WORD = 16'h3c5a
) (
    input wire logic [24:0] a,
    input wire logic [15:0] dq_i,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [15:0] dq_o,
    output logic [24:0] last_a
);
    logic [2:0] mode = 3'h0;
    logic [8:0] sec = 9'h0;
    logic lock = 1'b1;
    logic [511:0] nv = {256{2'b10}};
    logic [511:0] dv = '1;
    logic [15:0] otp [0:1023];
    logic [15:0] last_q = 16'h0;
    logic [15:0] q;
    logic [15:0] arr;
    wire logic [8:0] sa = a[24:16];
    assign arr = a[15:0] ^ {a[23:16], 8'h00} ^ 16'h5a5a;
    initial foreach (otp[i]) otp[i] = 16'hffff;
    always_comb
    begin
        case (mode)
            3'h1: q = (sa == sec) ? otp[a[9:0]] : arr;
            3'h2: q = LOCK_WORD;
            3'h3: q = {15'h7fff, nv[sa]};
            3'h4: q = {15'h7fff, lock};
            3'h5: q = (a < 25'h4) ? 16'h1110 + {14'h0, a[1:0]} : 16'hffff;
            3'h6: q = {15'h7fff, dv[sa]};
            3'h7: q = {12'hfff, a[6:4], 1'b1};
            default: q = arr;
        endcase
    end
    // a released bus shows the inverse of the last word, never a held value
    assign dq_o = (!ce_n && !oe_n) ? q : ~last_q;
    always @(posedge oe_n)
        if (ce_n === 1'b0)
            last_q <= q;
    always @(negedge oe_n or negedge we_n)
        last_a <= a;
    always @(posedge we_n)
    begin
        if (!ce_n && dq_i[15:4] == 12'hac0)
        begin
            mode <= (dq_i[2:0] == 3'h7 && mode != 3'h0) ? mode : dq_i[2:0];
            sec <= sa;
        end
        else if (!ce_n && dq_i == 16'h00f0)
            mode <= 3'h0;
        else if (!ce_n && mode == 3'h1 && sa == sec && a[15:10] == 6'h0 && a[9:8] != 2'h0)
            otp[a[9:0]] <= dq_i;
        else if (!ce_n && mode == 3'h3 && lock)
            nv[sa] <= dq_i[0];
        else if (!ce_n && mode == 3'h4)
            lock <= lock & dq_i[0];
        else if (!ce_n && mode == 3'h6)
            dv[sa] <= dq_i[0];
    end
endmodule
`default_nettype wire

/* File: fpo_tb.sv */
// self-checking bench for the flash protection overlay host
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] ra = 8'h00;
    logic [31:0] rw = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [24:0] fa;
    logic [24:0] last_a;
    logic [15:0] host_dq;
    logic [15:0] dev_dq;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic busy;
    int fails = 0;
    int comparisons = 0;
    wire logic [15:0] dq = dq_oe ? host_dq : dev_dq;
    always #5 clk = ~clk;
    fpo_flash_protection_host DUT (.CLK(clk), .RST_N(rst_n), .REG_ADDR(ra), .REG_WDATA(rw),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .FLASH_A(fa), .FLASH_DQ_I(dq),
        .FLASH_DQ_O(host_dq), .FLASH_DQ_OE(dq_oe), .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n),
        .FLASH_WE_N(we_n), .BUSY(busy));
    fpo_flash_model dev (.a(fa), .dq_i(dq), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .dq_o(dev_dq), .last_a(last_a));
    function automatic logic [15:0] arr(input logic [31:0] ad);
        return ad[15:0] ^ {ad[23:16], 8'h00} ^ 16'h5a5a;
    endfunction
    task automatic print_verdict();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // strobe drops for one cycle so a following call never re-drives it in the same step
    task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
        ra <= ad;
        rw <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic expect_reg(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
        ra <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHECK(rdata & m, e)
        @(posedge clk);
    endtask
    task automatic flash_op(input logic [2:0] op, input logic [2:0] kind,
        input logic [31:0] ad, input logic [15:0] d);
        int i;
        reg_write(fpo_pkg::REG_ADDR, ad);
        reg_write(fpo_pkg::REG_WDATA, {16'h0, d});
        reg_write(fpo_pkg::REG_CTRL, {25'h0, kind, 1'b0, op});
        #1;
        for (i = 0; i < 40 && busy !== 1'b0; i++)
        begin
            @(posedge clk);
            #1;
        end
        // a flash cycle that never ends is a failure, not a silent skip
        if (busy !== 1'b0)
        begin
            fails++;
            print_verdict();
        end
        @(posedge clk);
    endtask
    task automatic op_st(input logic [2:0] op, input logic [31:0] ad, input logic [15:0] d,
        input logic [31:0] m, input logic [31:0] e);
        flash_op(op, 3'h0, ad, d);
        expect_reg(fpo_pkg::REG_STATUS, m, e);
    endtask
    task automatic rd_exp(input logic [31:0] ad, input logic [15:0] e);
        flash_op(fpo_pkg::OP_READ, 3'h0, ad, 16'h0);
        expect_reg(fpo_pkg::REG_RDATA, 32'hffff, {16'h0, e});
    endtask
    task automatic enter(input logic [2:0] kind, input logic [31:0] ad);
        flash_op(fpo_pkg::OP_ENTER, kind, ad, 16'hac00 | {13'h0, kind});
        expect_reg(fpo_pkg::REG_STATUS, 32'h72, {25'h0, kind, 4'h0});
    endtask
    task automatic leave();
        flash_op(fpo_pkg::OP_EXIT, 3'h0, 32'h0, 16'h00f0);
        expect_reg(fpo_pkg::REG_STATUS, 32'h70, 32'h0);
    endtask
    initial
    begin
        #500000;
        fails++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        expect_reg(fpo_pkg::REG_STATUS, 32'hfff, 32'h0);
        expect_reg(fpo_pkg::REG_GATE, 32'hf, 32'h0);
        expect_reg(8'h3c, 32'hffffffff, 32'h0);
        rd_exp(32'h3_0123, arr(32'h3_0123));
        enter(3'h7, 32'h0);
        op_st(fpo_pkg::OP_RAW, 32'h10, 16'h55, 32'h2, 32'h2);
        for (int p = 0; p < 8; p++)
        begin
            flash_op(fpo_pkg::OP_READ, 3'h0, 32'h2_0003 | (32'(p) << 4), 16'h0);
            expect_reg(fpo_pkg::REG_DECODE, 32'he, 32'(p) << 1);
        end
        op_st(fpo_pkg::OP_PROGRAM, 32'h10, 16'h55, 32'h2, 32'h2);
        leave();
        enter(3'h1, 32'h3_0000);
        flash_op(fpo_pkg::OP_ENTER, 3'h7, 32'h0, 16'hac07);
        expect_reg(fpo_pkg::REG_STATUS, 32'h72, 32'h12);
        op_st(fpo_pkg::OP_PROGRAM, 32'h3_0150, 16'h1234, 32'h2, 32'h0);
        op_st(fpo_pkg::OP_PROGRAM, 32'h3_0010, 16'h0, 32'h2, 32'h2);
        rd_exp(32'h3_0150, 16'h1234);
        reg_write(fpo_pkg::REG_GATE, 32'h1);
        op_st(fpo_pkg::OP_PROGRAM, 32'h3_0151, 16'h0, 32'h2, 32'h2);
        op_st(fpo_pkg::OP_PROGRAM, 32'h3_0250, 16'h7, 32'h2, 32'h0);
        op_st(fpo_pkg::OP_PROGRAM, 32'h3_0350, 16'h7, 32'h2, 32'h2);
        rd_exp(32'h5_0150, arr(32'h5_0150));
        op_st(fpo_pkg::OP_READ, 32'h3_0350, 16'h0, 32'h2, 32'h2);
        op_st(fpo_pkg::OP_READ, 32'h3_0400, 16'h0, 32'h802, 32'h800);
        op_st(fpo_pkg::OP_PROGRAM, 32'h5_0150, 16'h7, 32'h2, 32'h2);
        reg_write(fpo_pkg::REG_GATE, 32'h9);
        for (int r = 0; r < 4; r++)
            op_st(fpo_pkg::OP_READ, 32'h3_0020 | (32'(r) << 8), 16'h0, 32'h302, 32'(r) << 8);
        reg_write(fpo_pkg::REG_GATE, 32'hd);
        op_st(fpo_pkg::OP_PROGRAM, 32'h3_0360, 16'h7, 32'h2, 32'h2);
        leave();
        rd_exp(32'h3_0150, arr(32'h3_0150));
        enter(3'h2, 32'h0);
        rd_exp(32'h3_1234, 16'h3c5a);
        `CHECK(last_a, 25'h0)
        leave();
        enter(3'h3, 32'h0);
        op_st(fpo_pkg::OP_READ, 32'h5_0044, 16'h0, 32'h2, 32'h0);
        expect_reg(fpo_pkg::REG_DECODE, 32'h1, 32'h1);
        `CHECK(last_a, 25'h5_0000)
        flash_op(fpo_pkg::OP_READ, 3'h0, 32'h4_0044, 16'h0);
        expect_reg(fpo_pkg::REG_DECODE, 32'h1, 32'h0);
        leave();
        enter(3'h4, 32'h0);
        flash_op(fpo_pkg::OP_READ, 3'h0, 32'h7, 16'h0);
        expect_reg(fpo_pkg::REG_DECODE, 32'h1, 32'h1);
        `CHECK(last_a, 25'h0)
        leave();
        enter(3'h5, 32'h0);
        rd_exp(32'h3, 16'h1113);
        op_st(fpo_pkg::OP_READ, 32'h5, 16'h0, 32'h800, 32'h800);
        leave();
        enter(3'h6, 32'h0);
        flash_op(fpo_pkg::OP_READ, 3'h0, 32'h6_0010, 16'h0);
        expect_reg(fpo_pkg::REG_DECODE, 32'h1, 32'h1);
        flash_op(fpo_pkg::OP_PROGRAM, 3'h0, 32'h6_0000, 16'h0);
        flash_op(fpo_pkg::OP_READ, 3'h0, 32'h6_0010, 16'h0);
        expect_reg(fpo_pkg::REG_DECODE, 32'h1, 32'h0);
        leave();
        print_verdict();
    end
endmodule
`default_nettype wire
